// ---- rtl/core_regs_consts.vh ----
// constants for the core status and pointer register bank
`ifndef CORE_REGS_CONSTS_VH
`define CORE_REGS_CONSTS_VH

// direct addresses of the special function space
`define SFR_SPACE_BASE      8'h80
`define ADDR_STACK_TOP      8'h81
`define ADDR_DPTR_LOW       8'h82
`define ADDR_DPTR_HIGH      8'h83
`define ADDR_STATUS_WORD    8'hD0
`define ADDR_PRIMARY_WORK   8'hE0
`define ADDR_SECONDARY_WORK 8'hF0

// reset values
`define RST_STACK_TOP       8'h07
`define RST_ZERO            8'h00

// status word field positions
`define SW_CARRY_BIT        7
`define SW_AUX_BIT          6
`define SW_USER0_BIT        5
`define SW_BANK_HI_BIT      4
`define SW_BANK_LO_BIT      3
`define SW_USER1_BIT        1

// writable bits of each register; bits 2 and 0 of the status word are reserved
`define MASK_ALL            8'hFF
`define MASK_STATUS_WORD    8'hFA
`define MASK_ALU_FLAGS      8'hC0
`define MASK_NONE           8'h00

// bit address layout: upper five bits name the byte, lower three the bit
`define BIT_BYTE_MASK       8'hF8
`define BIT_IDX_MSB         2
`define STACK_STEP          8'h01
`define BANK_BASE_PAD_HI    3'h0
`define BANK_BASE_PAD_LO    3'h0
`define READ_ZERO           8'h00

`endif

// ---- rtl/core_status_pointer_regs.v ----
// core register bank: stack top, data pointer, status word and work registers
`timescale 1ns/1ps
`include "core_regs_consts.vh"

module core_status_pointer_regs (
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        rst_n_in,
    // direct byte access
    input  wire        byte_wr_in,
    input  wire        byte_rd_in,
    input  wire [7:0]  byte_addr_in,
    input  wire [7:0]  byte_wdata_in,
    // direct bit access
    input  wire        bit_wr_in,
    input  wire        bit_rd_in,
    input  wire [7:0]  bit_addr_in,
    input  wire        bit_wdata_in,
    // arithmetic flag update
    input  wire        alu_flags_we_in,
    input  wire        alu_carry_in,
    input  wire        alu_aux_carry_in,
    // stack movement
    input  wire        stack_push_in,
    input  wire        stack_pop_in,
    // read answers
    output reg  [7:0]  rd_data_out,
    output reg         rd_valid_out,
    output reg         rd_reserved_out,
    output reg         bit_rd_data_out,
    output reg         bit_rd_valid_out,
    output reg         bit_rd_reserved_out,
    // register contents
    output wire [7:0]  stack_top_pointer_out,
    output wire [15:0] data_pointer_out,
    output wire [7:0]  program_status_word_out,
    output wire [7:0]  primary_work_register_out,
    output wire [7:0]  secondary_work_register_out,
    // status word fields
    output wire        carry_flag_out,
    output wire        aux_carry_flag_out,
    output wire        user_flag_zero_out,
    output wire        user_flag_one_out,
    output wire [1:0]  bank_select_out,
    output wire [7:0]  reg_bank_base_out
);
    wire [7:0] stack_top_pointer;
    wire [7:0] data_pointer_low;
    wire [7:0] data_pointer_high;
    wire [7:0] program_status_word;
    wire [7:0] primary_work_register;
    wire [7:0] secondary_work_register;

    // below 0x80 a direct address is data memory, not this bank
    wire       byte_in_space = (byte_addr_in >= `SFR_SPACE_BASE);
    wire       bit_in_space  = (bit_addr_in >= `SFR_SPACE_BASE);
    wire [7:0] bit_byte_addr = bit_addr_in & `BIT_BYTE_MASK;
    wire [2:0] bit_idx       = bit_addr_in[`BIT_IDX_MSB:0];

    wire we_stack  = byte_wr_in && byte_in_space && (byte_addr_in == `ADDR_STACK_TOP);
    wire we_dpl    = byte_wr_in && byte_in_space && (byte_addr_in == `ADDR_DPTR_LOW);
    wire we_dph    = byte_wr_in && byte_in_space && (byte_addr_in == `ADDR_DPTR_HIGH);
    wire we_status = byte_wr_in && byte_in_space && (byte_addr_in == `ADDR_STATUS_WORD);
    wire we_prim   = byte_wr_in && byte_in_space && (byte_addr_in == `ADDR_PRIMARY_WORK);
    wire we_sec    = byte_wr_in && byte_in_space && (byte_addr_in == `ADDR_SECONDARY_WORK);

    // only the registers at 0xD0, 0xE0 and 0xF0 accept bit writes
    wire bw_status = bit_wr_in && bit_in_space && (bit_byte_addr == `ADDR_STATUS_WORD);
    wire bw_prim   = bit_wr_in && bit_in_space && (bit_byte_addr == `ADDR_PRIMARY_WORK);
    wire bw_sec    = bit_wr_in && bit_in_space && (bit_byte_addr == `ADDR_SECONDARY_WORK);

    // pre-increment on push, post-decrement on pop; both at once cancel
    reg  [7:0] stack_hw_mask;
    reg  [7:0] stack_hw_val;
    always @*
    begin
        stack_hw_mask = `MASK_NONE;
        stack_hw_val  = stack_top_pointer;
        if (stack_push_in && !stack_pop_in)
        begin
            stack_hw_mask = `MASK_ALL;
            stack_hw_val  = stack_top_pointer + `STACK_STEP;
        end
        else if (stack_pop_in && !stack_push_in)
        begin
            stack_hw_mask = `MASK_ALL;
            stack_hw_val  = stack_top_pointer - `STACK_STEP;
        end
    end

    // hardware touches only carry and aux carry; user flags and bank bits stay software-only
    wire [7:0] status_hw_mask = alu_flags_we_in ? `MASK_ALU_FLAGS : `MASK_NONE;
    wire [7:0] status_hw_val  = {alu_carry_in, alu_aux_carry_in, 6'h00};

    sfr_byte_reg #(
        .RESET_VAL  (`RST_STACK_TOP),
        .WRITE_MASK (`MASK_ALL),
        .BIT_ACCESS (0)
    ) u_stack_top (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .byte_we_in   (we_stack),
        .byte_data_in (byte_wdata_in),
        .bit_we_in    (1'b0),
        .bit_idx_in   (bit_idx),
        .bit_val_in   (bit_wdata_in),
        .hw_mask_in   (stack_hw_mask),
        .hw_val_in    (stack_hw_val),
        .value_out    (stack_top_pointer)
    );

    sfr_byte_reg #(
        .RESET_VAL  (`RST_ZERO),
        .WRITE_MASK (`MASK_ALL),
        .BIT_ACCESS (0)
    ) u_dptr_low (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .byte_we_in   (we_dpl),
        .byte_data_in (byte_wdata_in),
        .bit_we_in    (1'b0),
        .bit_idx_in   (bit_idx),
        .bit_val_in   (bit_wdata_in),
        .hw_mask_in   (`MASK_NONE),
        .hw_val_in    (`RST_ZERO),
        .value_out    (data_pointer_low)
    );

    sfr_byte_reg #(
        .RESET_VAL  (`RST_ZERO),
        .WRITE_MASK (`MASK_ALL),
        .BIT_ACCESS (0)
    ) u_dptr_high (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .byte_we_in   (we_dph),
        .byte_data_in (byte_wdata_in),
        .bit_we_in    (1'b0),
        .bit_idx_in   (bit_idx),
        .bit_val_in   (bit_wdata_in),
        .hw_mask_in   (`MASK_NONE),
        .hw_val_in    (`RST_ZERO),
        .value_out    (data_pointer_high)
    );

    sfr_byte_reg #(
        .RESET_VAL  (`RST_ZERO),
        .WRITE_MASK (`MASK_STATUS_WORD),
        .BIT_ACCESS (1)
    ) u_status_word (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .byte_we_in   (we_status),
        .byte_data_in (byte_wdata_in),
        .bit_we_in    (bw_status),
        .bit_idx_in   (bit_idx),
        .bit_val_in   (bit_wdata_in),
        .hw_mask_in   (status_hw_mask),
        .hw_val_in    (status_hw_val),
        .value_out    (program_status_word)
    );

    sfr_byte_reg #(
        .RESET_VAL  (`RST_ZERO),
        .WRITE_MASK (`MASK_ALL),
        .BIT_ACCESS (1)
    ) u_primary_work (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .byte_we_in   (we_prim),
        .byte_data_in (byte_wdata_in),
        .bit_we_in    (bw_prim),
        .bit_idx_in   (bit_idx),
        .bit_val_in   (bit_wdata_in),
        .hw_mask_in   (`MASK_NONE),
        .hw_val_in    (`RST_ZERO),
        .value_out    (primary_work_register)
    );

    sfr_byte_reg #(
        .RESET_VAL  (`RST_ZERO),
        .WRITE_MASK (`MASK_ALL),
        .BIT_ACCESS (1)
    ) u_secondary_work (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .byte_we_in   (we_sec),
        .byte_data_in (byte_wdata_in),
        .bit_we_in    (bw_sec),
        .bit_idx_in   (bit_idx),
        .bit_val_in   (bit_wdata_in),
        .hw_mask_in   (`MASK_NONE),
        .hw_val_in    (`RST_ZERO),
        .value_out    (secondary_work_register)
    );

    // byte read decode; anything unclaimed reads zero and is flagged reserved
    reg [7:0] rd_data_next;
    reg       rd_reserved_next;
    always @*
    begin
        rd_data_next     = `READ_ZERO;
        rd_reserved_next = 1'b0;
        if (!byte_in_space)
            rd_reserved_next = 1'b1;
        else if (byte_addr_in == `ADDR_STACK_TOP)
            rd_data_next = stack_top_pointer;
        else if (byte_addr_in == `ADDR_DPTR_LOW)
            rd_data_next = data_pointer_low;
        else if (byte_addr_in == `ADDR_DPTR_HIGH)
            rd_data_next = data_pointer_high;
        else if (byte_addr_in == `ADDR_STATUS_WORD)
            rd_data_next = program_status_word;
        else if (byte_addr_in == `ADDR_PRIMARY_WORK)
            rd_data_next = primary_work_register;
        else if (byte_addr_in == `ADDR_SECONDARY_WORK)
            rd_data_next = secondary_work_register;
        else
            rd_reserved_next = 1'b1;
    end

    // bit read decode; only bit-addressable bytes answer
    reg bit_data_next;
    reg bit_reserved_next;
    always @*
    begin
        bit_data_next     = 1'b0;
        bit_reserved_next = 1'b0;
        if (!bit_in_space)
            bit_reserved_next = 1'b1;
        else if (bit_byte_addr == `ADDR_STATUS_WORD)
            bit_data_next = program_status_word[bit_idx];
        else if (bit_byte_addr == `ADDR_PRIMARY_WORK)
            bit_data_next = primary_work_register[bit_idx];
        else if (bit_byte_addr == `ADDR_SECONDARY_WORK)
            bit_data_next = secondary_work_register[bit_idx];
        else
            bit_reserved_next = 1'b1;
    end

    // read answers are registered one cycle after the request
    always @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rd_data_out         <= `READ_ZERO;
            rd_valid_out        <= 1'b0;
            rd_reserved_out     <= 1'b0;
            bit_rd_data_out     <= 1'b0;
            bit_rd_valid_out    <= 1'b0;
            bit_rd_reserved_out <= 1'b0;
        end
        else
        begin
            rd_valid_out        <= byte_rd_in;
            rd_data_out         <= byte_rd_in ? rd_data_next : `READ_ZERO;
            rd_reserved_out     <= byte_rd_in && rd_reserved_next;
            bit_rd_valid_out    <= bit_rd_in;
            bit_rd_data_out     <= bit_rd_in && bit_data_next;
            bit_rd_reserved_out <= bit_rd_in && bit_reserved_next;
        end
    end

    // content outputs are taken straight from the register flops
    assign stack_top_pointer_out       = stack_top_pointer;
    assign data_pointer_out            = {data_pointer_high, data_pointer_low};
    assign program_status_word_out     = program_status_word;
    assign primary_work_register_out   = primary_work_register;
    assign secondary_work_register_out = secondary_work_register;
    assign carry_flag_out              = program_status_word[`SW_CARRY_BIT];
    assign aux_carry_flag_out          = program_status_word[`SW_AUX_BIT];
    assign user_flag_zero_out          = program_status_word[`SW_USER0_BIT];
    assign user_flag_one_out           = program_status_word[`SW_USER1_BIT];
    assign bank_select_out             = {program_status_word[`SW_BANK_HI_BIT],
                                          program_status_word[`SW_BANK_LO_BIT]};
    assign reg_bank_base_out           = {`BANK_BASE_PAD_HI, bank_select_out,
                                          `BANK_BASE_PAD_LO};
endmodule // core_status_pointer_regs

// ---- rtl/sfr_byte_reg.v ----
// one byte-wide register with byte, bit and hardware update ports
`timescale 1ns/1ps
module sfr_byte_reg #(
    parameter [7:0] RESET_VAL  = 8'h00,
    parameter [7:0] WRITE_MASK = 8'hFF,
    parameter       BIT_ACCESS = 0
) (
    // clock and reset
    input  wire       clk_sys_in,
    input  wire       rst_n_in,
    // software byte write
    input  wire       byte_we_in,
    input  wire [7:0] byte_data_in,
    // software single-bit write
    input  wire       bit_we_in,
    input  wire [2:0] bit_idx_in,
    input  wire       bit_val_in,
    // hardware update of selected bits
    input  wire [7:0] hw_mask_in,
    input  wire [7:0] hw_val_in,
    // stored value
    output wire [7:0] value_out
);
    reg [7:0] value_reg;
    reg [7:0] value_next;

    always @*
    begin
        value_next = (value_reg & ~hw_mask_in) | (hw_val_in & hw_mask_in);
        // software comes last so an explicit write beats a hardware update
        if (byte_we_in)
        begin
            value_next = byte_data_in;
        end
        if (bit_we_in && (BIT_ACCESS != 0))
        begin
            value_next[bit_idx_in] = bit_val_in;
        end
        // reserved bits never leave zero
        value_next = value_next & WRITE_MASK;
    end

    always @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            value_reg <= RESET_VAL & WRITE_MASK;
        end
        else
        begin
            value_reg <= value_next;
        end
    end

    assign value_out = value_reg;
endmodule // sfr_byte_reg

// ---- verification/core_status_pointer_regs_asserts.sv ----
// concurrent checks on the core register bank ports
`timescale 1ns/1ps
module core_status_pointer_regs_asserts (
    // clock and reset
    input wire        clk_sys_in,
    input wire        rst_n_in,
    // requests
    input wire        byte_wr_in,
    input wire        byte_rd_in,
    input wire [7:0]  byte_addr_in,
    input wire [7:0]  byte_wdata_in,
    input wire        bit_wr_in,
    input wire        alu_flags_we_in,
    input wire        alu_carry_in,
    input wire        alu_aux_carry_in,
    input wire        stack_push_in,
    input wire        stack_pop_in,
    // answers and contents
    input wire [7:0]  rd_data_out,
    input wire        rd_valid_out,
    input wire        rd_reserved_out,
    input wire [7:0]  stack_top_pointer_out,
    input wire [15:0] data_pointer_out,
    input wire [7:0]  program_status_word_out,
    input wire        carry_flag_out,
    input wire        aux_carry_flag_out,
    input wire        user_flag_zero_out,
    input wire        user_flag_one_out
);
    wire       sw_write = byte_wr_in | bit_wr_in;
    wire [7:0] dptr_low = data_pointer_out[7:0];
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_read_answer: assert property (byte_rd_in |=> rd_valid_out)
        else $error("byte read not answered next cycle");
    a_low_addr_reserved: assert property (byte_rd_in && byte_addr_in < 8'h80
        |=> rd_reserved_out && rd_data_out == 8'h00) else $error("low address not reserved");
    a_status_read_old: assert property (byte_rd_in && byte_addr_in == 8'hD0
        |=> !rd_reserved_out && rd_data_out == $past(program_status_word_out))
        else $error("status word read wrong");
    a_reserved_bits_zero: assert property (program_status_word_out[2] == 1'b0
        && program_status_word_out[0] == 1'b0) else $error("reserved status bit set");
    a_alu_flag_load: assert property (alu_flags_we_in && !sw_write
        |=> carry_flag_out == $past(alu_carry_in) && aux_carry_flag_out == $past(alu_aux_carry_in))
        else $error("arithmetic flags not loaded");
    a_user_flag_hold: assert property (!sw_write
        |=> $stable(user_flag_zero_out) && $stable(user_flag_one_out))
        else $error("user flag changed without software");
    a_push_step: assert property (stack_push_in && !stack_pop_in && !sw_write
        |=> stack_top_pointer_out == $past(stack_top_pointer_out) + 8'h01)
        else $error("push did not step stack pointer");
    a_dptr_high_only: assert property (byte_wr_in && byte_addr_in == 8'h83
        |=> data_pointer_out[15:8] == $past(byte_wdata_in) && dptr_low == $past(dptr_low))
        else $error("pointer high write wrong");

    c_status_read: cover property (byte_rd_in && byte_addr_in == 8'hD0);
    c_alu_load: cover property (alu_flags_we_in && !sw_write);
    c_push: cover property (stack_push_in && !stack_pop_in);
endmodule  // core_status_pointer_regs_asserts

// ---- verification/tb_core_status_pointer_regs.sv ----
// self-checking bench for the core status and pointer register bank
`timescale 1ns/1ps
module tb_core_status_pointer_regs;
    logic        clk_sys_in, rst_n_in, byte_wr_in, byte_rd_in, bit_wr_in, bit_rd_in;
    logic        bit_wdata_in, alu_flags_we_in, alu_carry_in, alu_aux_carry_in;
    logic        stack_push_in, stack_pop_in, rd_valid_out, rd_reserved_out, carry_flag_out;
    logic        bit_rd_data_out, bit_rd_valid_out, bit_rd_reserved_out, aux_carry_flag_out;
    logic        user_flag_zero_out, user_flag_one_out;
    logic [1:0]  bank_select_out;
    logic [7:0]  byte_addr_in, byte_wdata_in, bit_addr_in, rd_data_out, stack_top_pointer_out;
    logic [7:0]  program_status_word_out, primary_work_register_out, reg_bank_base_out;
    logic [7:0]  secondary_work_register_out, rnd, op, ra, rt;
    logic [15:0] data_pointer_out;
    logic [7:0]  m [0:255];  // reference copy of the registers
    logic [7:0]  tab [0:7] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'h84, 8'h7F};
    logic [8:0]  byte_q [$];
    logic [1:0]  bit_q [$];
    int          err_total, check_count;

    core_status_pointer_regs i_core_status_pointer_regs (
        .clk_sys_in, .rst_n_in, .byte_wr_in, .byte_rd_in, .byte_addr_in, .byte_wdata_in,
        .bit_wr_in, .bit_rd_in, .bit_addr_in, .bit_wdata_in, .alu_flags_we_in, .alu_carry_in,
        .alu_aux_carry_in, .stack_push_in, .stack_pop_in, .rd_data_out, .rd_valid_out,
        .rd_reserved_out, .bit_rd_data_out, .bit_rd_valid_out, .bit_rd_reserved_out,
        .stack_top_pointer_out, .data_pointer_out, .program_status_word_out,
        .primary_work_register_out, .secondary_work_register_out, .carry_flag_out,
        .aux_carry_flag_out, .user_flag_zero_out, .user_flag_one_out, .bank_select_out,
        .reg_bank_base_out);

    always #12.5 clk_sys_in = ~clk_sys_in;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic mapped(input logic [7:0] ad);
        mapped = ad inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
    endfunction

    task automatic chk(input string n, input logic [63:0] e, g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic regs_ok;
        chk("regs", {m[8'h81], m[8'h83], m[8'h82],
                     m[8'hD0], m[8'hE0], m[8'hF0]},
            {stack_top_pointer_out, data_pointer_out, program_status_word_out,
             primary_work_register_out, secondary_work_register_out});
        chk("fields", {m[8'hD0][7:5], m[8'hD0][1], m[8'hD0][4:3],
                       3'b000, m[8'hD0][4:3], 3'b000},
            {carry_flag_out, aux_carry_flag_out, user_flag_zero_out, user_flag_one_out,
             bank_select_out, reg_bank_base_out[7:3], reg_bank_base_out[2:0]});
    endtask

    // drives one cycle at the falling edge and notes what the design must answer
    task automatic cyc(input logic bw, br, input logic [7:0] ad, dt, input logic tw, tr,
                       input logic [7:0] ta, input logic tv, aw, cy, ac, pu, po);
        logic [7:0] tb8;
        logic       tok;
        tb8 = {ta[7:3], 3'b000};
        tok = tb8 inside {8'hD0, 8'hE0, 8'hF0};
        {byte_wr_in, byte_rd_in, byte_addr_in, byte_wdata_in} = {bw, br, ad, dt};
        {bit_wr_in, bit_rd_in, bit_addr_in, bit_wdata_in} = {tw, tr, ta, tv};
        {alu_flags_we_in, alu_carry_in, alu_aux_carry_in} = {aw, cy, ac};
        {stack_push_in, stack_pop_in} = {pu, po};
        if (br) byte_q.push_back({!mapped(ad), mapped(ad) ? m[ad] : 8'h00});
        if (tr) bit_q.push_back({!tok, tok && m[tb8][ta[2:0]]});
        if (aw) m[8'hD0][7:6] = {cy, ac};
        if (pu != po) m[8'h81] = pu ? m[8'h81] + 8'h01 : m[8'h81] - 8'h01;
        if (bw && mapped(ad)) m[ad] = dt;
        if (tw && tok) m[tb8][ta[2:0]] = tv;
        @(negedge clk_sys_in);
        if (rst_n_in) regs_ok;
    endtask

    task automatic wr(input logic [7:0] ad, dt);
        cyc('1, '0, ad, dt, '0, '0, '0, '0, '0, '0, '0, '0, '0);
    endtask
    task automatic rd(input logic [7:0] ad);
        cyc('0, '1, ad, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0);
    endtask
    task automatic bw(input logic [7:0] ta, input logic v);
        cyc('0, '0, '0, '0, '1, '0, ta, v, '0, '0, '0, '0, '0);
    endtask
    task automatic br(input logic [7:0] ta);
        cyc('0, '0, '0, '0, '0, '1, ta, '0, '0, '0, '0, '0, '0);
    endtask
    task automatic ms(input logic pu, po);
        cyc('0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, pu, po);
    endtask

    task automatic do_reset;
        rst_n_in = '0;
        ms('0, '0);
        repeat (11) @(negedge clk_sys_in);
        rst_n_in = '1;
        foreach (m[i]) m[i] = 8'h00;
        m[8'h81] = 8'h07;
        regs_ok;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(negedge clk_sys_in)
    begin
        if (rd_valid_out === 1'b1)
            chk("byte read", byte_q.size() ? byte_q.pop_front() : 16'hFFFF,
                {rd_reserved_out, rd_data_out});
        if (bit_rd_valid_out === 1'b1)
            chk("bit read", bit_q.size() ? bit_q.pop_front() : 16'hFFFF,
                {bit_rd_reserved_out, bit_rd_data_out});
    end

    initial
    begin
        clk_sys_in = '0;
        rst_n_in = '0;
        err_total = 0;
        check_count = 0;
        rnd = 8'h08;
        do_reset;
        $display("test reset done");
        for (int i = 0; i < 4; i++)
            cyc('1, '1, 8'hD0, {3'b000, i[1:0], 3'b000}, '0, '0, '0, '0, '0, '0, '0, '0, '0);
        rd(8'hD0);
        bw(8'hD5, '1);
        bw(8'hD1, '1);
        for (int i = 0; i < 4; i++)
            cyc('0, '1, 8'hD0, '0, '0, '1, 8'hD7, '0, '1, i[1], i[0], '0, '0);
        br(8'hD6);
        br(8'hD2);
        $display("test status word done");
        ms('1, '0);
        ms('1, '1);
        ms('0, '1);
        wr(8'h81, 8'hFF);
        cyc('0, '1, 8'h81, '0, '0, '0, '0, '0, '0, '0, '0, '1, '0);
        cyc('1, '0, 8'h81, 8'h40, '0, '0, '0, '0, '0, '0, '0, '1, '0);
        $display("test stack done");
        wr(8'h82, 8'h5A);
        wr(8'h83, 8'hA5);
        rd(8'h82);
        rd(8'h83);
        wr(8'hE0, 8'h3C);
        bw(8'hE7, '1);
        bw(8'hF0, '1);
        $display("test pointer and work registers done");
        wr(8'h84, 8'hFF);
        foreach (tab[i]) rd(tab[i]);
        rd(8'hD1);
        br(8'h80);
        bw(8'h88, '1);
        br(8'h88);
        $display("test reserved addresses done");
        for (int n = 0; n < 300; n++)
        begin
            rnd = lfsr(rnd);
            op = rnd;
            rnd = lfsr(rnd);
            ra = tab[rnd[2:0]];
            rt = {tab[rnd[5:3]][7:3], rnd[7:5]};
            rnd = lfsr(rnd);
            // software keeps the reserved status bits at zero
            if (op[7]) cyc('0, '0, '0, '0, '0, '0, '0, '0, op[0], op[1], op[2], op[3], op[4]);
            else cyc(op[0], op[1], ra, ra == 8'hD0 ? rnd & 8'hFA : rnd, op[2], op[3], rt,
                     rnd[0] & !(rt[7:3] == 5'h1A && !rt[0] && !rt[2]), '0, '0, '0, '0, '0);
        end
        $display("test random done");
        do_reset;
        $display("test second reset done");
        ms('0, '0);
        chk("pending", '0, byte_q.size() + bit_q.size());
        stop_test;
    end

    // the tests take about 365 cycles
    initial
    begin
        repeat (3000) @(posedge clk_sys_in);
        err_total++;
        stop_test;
    end
endmodule  // tb_core_status_pointer_regs

bind core_status_pointer_regs core_status_pointer_regs_asserts i_core_status_pointer_regs_asserts (
    .clk_sys_in, .rst_n_in, .byte_wr_in, .byte_rd_in, .byte_addr_in, .byte_wdata_in,
    .bit_wr_in, .alu_flags_we_in, .alu_carry_in, .alu_aux_carry_in, .stack_push_in,
    .stack_pop_in, .rd_data_out, .rd_valid_out, .rd_reserved_out, .stack_top_pointer_out,
    .data_pointer_out, .program_status_word_out, .carry_flag_out, .aux_carry_flag_out,
    .user_flag_zero_out, .user_flag_one_out);
